// file: snfr_defines.vh
// Feature register constants: addresses, bit positions, reset values, opcodes
`ifndef SNFR_DEFINES_VH
`define SNFR_DEFINES_VH

// Feature addresses
`define SNFR_ADDR_LOCK        8'hA0
`define SNFR_ADDR_CFG         8'hB0
`define SNFR_ADDR_STATUS      8'hC0

// Serial opcodes
`define SNFR_OP_SET_FEATURE   8'h1F
`define SNFR_OP_GET_FEATURE   8'h0F
`define SNFR_OP_WRITE_ENABLE  8'h06
`define SNFR_OP_WRITE_DISABLE 8'h04
`define SNFR_OP_PROTECT_EXEC  8'h2A

// Lock byte fields
`define SNFR_LOCK_GUARD_BIT   7
`define SNFR_LOCK_RANGE_HI    5
`define SNFR_LOCK_RANGE_LO    3
`define SNFR_LOCK_GUARD_RST   1'h0
`define SNFR_LOCK_RANGE_RST   3'h7

// Configuration byte fields
`define SNFR_CFG_PPAGE_BIT    6
`define SNFR_CFG_ECC_BIT      4
`define SNFR_CFG_PROT_BIT     2
`define SNFR_CFG_FAST_BIT     1
`define SNFR_CFG_HOLD_BIT     0
`define SNFR_CFG_PPAGE_RST    1'h0
`define SNFR_CFG_ECC_RST      1'h1
`define SNFR_CFG_PROT_RST     1'h0
`define SNFR_CFG_FAST_RST     1'h1
`define SNFR_CFG_HOLD_RST     1'h0

// Status byte fields
`define SNFR_STAT_ECC_HI      5
`define SNFR_STAT_ECC_LO      4
`define SNFR_STAT_PFAIL_BIT   3
`define SNFR_STAT_EFAIL_BIT   2
`define SNFR_STAT_WPL_BIT     1
`define SNFR_STAT_BUSY_BIT    0
`define SNFR_WPL_RST          1'h0

// Correction result codes
`define SNFR_ECC_CLEAN        2'h0
`define SNFR_ECC_FIXED_LOW    2'h1
`define SNFR_ECC_UNFIXABLE    2'h2
`define SNFR_ECC_FIXED_HIGH   2'h3

// Array size used for the lock boundary
`define SNFR_BLOCK_COUNT      12'h800

`endif

// file: snfr_pin_sync.v
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module snfr_pin_sync #(
  parameter       WIDTH     = 4,
  parameter [3:0] RESET_VAL = 4'h0
) (
  input  wire             clock,
  input  wire             reset,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out
);

  genvar g;
  // ************************************************************
  // Per-lane flip-flop chain
  // ************************************************************
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_lane
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      // First stage feeds only the second stage
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          s1_q  <= RESET_VAL[g];
          s2_q  <= RESET_VAL[g];
          s3_q  <= RESET_VAL[g];
          out_q <= RESET_VAL[g];
        end else begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q; // Accept once stages two and three agree
          end
        end
      end
      assign pin_out[g] = out_q;
    end
  endgenerate

endmodule // snfr_pin_sync

// file: snfr_feature_regs.v
// Serial NAND feature register bank with its serial command front end
`timescale 1ns/1ps
`include "snfr_defines.vh"
module snfr_feature_regs (
  input  wire        clock,
  input  wire        reset,
  input  wire        spi_cs_n,
  input  wire        spi_sck,
  input  wire        spi_si,
  output wire        spi_so,
  output wire        spi_so_oe_n,
  input  wire        wp_n,
  input  wire        op_busy,
  input  wire        prog_done,
  input  wire        prog_fail,
  input  wire        erase_done,
  input  wire        erase_fail,
  input  wire        cmd_accepted,
  input  wire        ecc_done,
  input  wire        ecc_uncorrectable,
  input  wire [3:0]  ecc_flip_count,
  input  wire [3:0]  ecc_threshold,
  output wire [7:0]  cmd_opcode,
  output wire        cmd_valid,
  output wire        protect_exec_ok,
  output wire        param_page_mode,
  output wire        ecc_enable,
  output wire        fast_read_mode,
  output wire        hold_disable,
  output wire        write_permit_latch,
  output wire [11:0] lock_first_block
);
  // ************************************************************
  // Frame state codes
  // ************************************************************
  localparam [2:0] ST_OPC  = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_OUT  = 3'h3;
  localparam [2:0] ST_SKIP = 3'h4;
  // ************************************************************
  // Pin synchronisers and serial clock edges
  // ************************************************************
  wire       cs_n_s, sck_s, si_s, wp_n_s;
  wire       sck_rise, sck_fall;
  reg        sck_prev_q;
  // Chip select and write protect idle high
  snfr_pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'h9)
  ) u_sync (
    .clock   (clock),
    .reset   (reset),
    .pin_in  ({wp_n, spi_si, spi_sck, spi_cs_n}),
    .pin_out ({wp_n_s, si_s, sck_s, cs_n_s})
  );
  // Previous serial clock level, idle low
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sck_prev_q <= 1'h0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end
  assign sck_rise = ~cs_n_s & sck_s & ~sck_prev_q;
  assign sck_fall = ~cs_n_s & ~sck_s & sck_prev_q;
  // ************************************************************
  // Feature storage, receive path and frame state
  // ************************************************************
  reg        lock_guard_q, ppage_q, ecc_en_q, prot_arm_q, fast_q, hold_dis_q;
  reg        wpl_q, pfail_q, efail_q, cmd_valid_q, prot_ok_q, wr_pulse_q;
  reg  [1:0] ecc_code_q;
  reg  [2:0] lock_range_q, state_q, bit_cnt_q;
  reg  [7:0] rx_q, opc_q, addr_q, cmd_opc_q, wr_data_q;
  wire [7:0] rx_byte;
  wire       byte_end;
  assign rx_byte  = {rx_q[6:0], si_s};
  assign byte_end = sck_rise & (bit_cnt_q == 3'h7);
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_q      <= 8'h00;
      bit_cnt_q <= 3'h0;
    end else if (cs_n_s) begin
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      rx_q      <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // Frame sequencing by opcode
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q     <= ST_OPC;
      opc_q       <= 8'h00;
      addr_q      <= 8'h00;
      cmd_opc_q   <= 8'h00;
      cmd_valid_q <= 1'h0;
      prot_ok_q   <= 1'h0;
      wr_pulse_q  <= 1'h0;
      wr_data_q   <= 8'h00;
    end else begin
      cmd_valid_q <= 1'h0;
      prot_ok_q   <= 1'h0;
      wr_pulse_q  <= 1'h0;
      if (cs_n_s) begin
        state_q <= ST_OPC;
      end else if (byte_end) begin
        case (state_q)
          ST_OPC: begin
            opc_q       <= rx_byte;
            cmd_opc_q   <= rx_byte;
            cmd_valid_q <= 1'h1;
            prot_ok_q   <= (rx_byte == `SNFR_OP_PROTECT_EXEC) & prot_arm_q;
            // set and get take an address
            if ((rx_byte == `SNFR_OP_SET_FEATURE) ||
                (rx_byte == `SNFR_OP_GET_FEATURE)) begin
              state_q <= ST_ADDR;
            end else begin
              state_q <= ST_SKIP;
            end
          end
          ST_ADDR: begin
            addr_q  <= rx_byte;
            state_q <= (opc_q == `SNFR_OP_SET_FEATURE) ? ST_DATA : ST_OUT;
          end
          ST_DATA: begin
            wr_data_q  <= rx_byte;
            wr_pulse_q <= 1'h1;
            state_q    <= ST_SKIP;
          end
          ST_OUT:  state_q <= ST_OUT;
          ST_SKIP: state_q <= ST_SKIP;
          default: state_q <= ST_SKIP;
        endcase
      end
    end
  end

  // ************************************************************
  // Feature-set writes
  // ************************************************************
  wire lock_frozen;
  assign lock_frozen = lock_guard_q & ~wp_n_s;
  // only the power-up reset restores defaults
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      lock_guard_q <= `SNFR_LOCK_GUARD_RST;
      lock_range_q <= `SNFR_LOCK_RANGE_RST;
      ppage_q      <= `SNFR_CFG_PPAGE_RST;
      ecc_en_q     <= `SNFR_CFG_ECC_RST;
      prot_arm_q   <= `SNFR_CFG_PROT_RST;
      fast_q       <= `SNFR_CFG_FAST_RST;
      hold_dis_q   <= `SNFR_CFG_HOLD_RST;
    end else if (wr_pulse_q) begin
      case (addr_q)
        `SNFR_ADDR_LOCK: begin
          if (!lock_frozen) begin
            lock_guard_q <= wr_data_q[`SNFR_LOCK_GUARD_BIT];
            lock_range_q <= wr_data_q[`SNFR_LOCK_RANGE_HI:`SNFR_LOCK_RANGE_LO];
          end
        end
        `SNFR_ADDR_CFG: begin
          ppage_q    <= wr_data_q[`SNFR_CFG_PPAGE_BIT];
          ecc_en_q   <= wr_data_q[`SNFR_CFG_ECC_BIT];
          prot_arm_q <= wr_data_q[`SNFR_CFG_PROT_BIT];
          fast_q     <= wr_data_q[`SNFR_CFG_FAST_BIT];
          hold_dis_q <= wr_data_q[`SNFR_CFG_HOLD_BIT];
        end
        // status and unknown addresses ignore writes
        default: ppage_q <= ppage_q;
      endcase
    end
  end

  // ************************************************************
  // Write permit latch, result flags and correction code
  // ************************************************************
  // only enable and disable opcodes
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wpl_q <= `SNFR_WPL_RST;
    end else if (cmd_valid_q) begin
      if (cmd_opc_q == `SNFR_OP_WRITE_ENABLE) begin
        wpl_q <= 1'h1;
      end else if (cmd_opc_q == `SNFR_OP_WRITE_DISABLE) begin
        wpl_q <= 1'h0;
      end
    end
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pfail_q <= 1'h0;
      efail_q <= 1'h0;
    end else begin
      if (prog_done) begin
        pfail_q <= prog_fail;
      end else if (cmd_accepted) begin
        pfail_q <= 1'h0;
      end
      if (erase_done) begin
        efail_q <= erase_fail;
      end else if (cmd_accepted) begin
        efail_q <= 1'h0;
      end
    end
  end
  reg [1:0] ecc_code_d;
  always @* begin
    if (ecc_uncorrectable) begin
      ecc_code_d = `SNFR_ECC_UNFIXABLE;
    end else if (ecc_flip_count == 4'h0) begin
      ecc_code_d = `SNFR_ECC_CLEAN;
    end else if (ecc_flip_count < ecc_threshold) begin
      ecc_code_d = `SNFR_ECC_FIXED_LOW;
    end else begin
      ecc_code_d = `SNFR_ECC_FIXED_HIGH;
    end
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ecc_code_q <= `SNFR_ECC_CLEAN;
    end else if (ecc_done && ecc_en_q) begin
      ecc_code_q <= ecc_code_d;
    end
  end

  // ************************************************************
  // Read-back byte selection
  // ************************************************************
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (addr_q)
      `SNFR_ADDR_LOCK: begin
        rd_byte[`SNFR_LOCK_GUARD_BIT] = lock_guard_q;
        rd_byte[`SNFR_LOCK_RANGE_HI:`SNFR_LOCK_RANGE_LO] = lock_range_q;
      end
      `SNFR_ADDR_CFG: begin
        rd_byte[`SNFR_CFG_PPAGE_BIT] = ppage_q;
        rd_byte[`SNFR_CFG_ECC_BIT]   = ecc_en_q;
        rd_byte[`SNFR_CFG_PROT_BIT]  = prot_arm_q;
        rd_byte[`SNFR_CFG_FAST_BIT]  = fast_q;
        rd_byte[`SNFR_CFG_HOLD_BIT]  = hold_dis_q;
      end
      `SNFR_ADDR_STATUS: begin
        rd_byte[`SNFR_STAT_ECC_HI:`SNFR_STAT_ECC_LO] = ecc_code_q;
        rd_byte[`SNFR_STAT_PFAIL_BIT] = pfail_q;
        rd_byte[`SNFR_STAT_EFAIL_BIT] = efail_q;
        rd_byte[`SNFR_STAT_WPL_BIT]   = wpl_q;
        rd_byte[`SNFR_STAT_BUSY_BIT]  = op_busy;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // ************************************************************
  // Feature-get shifter
  // ************************************************************
  reg [6:0] tx_q;
  reg [2:0] tx_cnt_q;
  reg       so_q;
  reg       so_en_q;
  // reload a fresh byte every eight bits
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_q     <= 7'h00;
      tx_cnt_q <= 3'h0;
      so_q     <= 1'h0;
      so_en_q  <= 1'h0;
    end else if (cs_n_s) begin
      tx_cnt_q <= 3'h0;
      so_q     <= 1'h0;
      so_en_q  <= 1'h0;
    end else if (sck_fall && (state_q == ST_OUT)) begin
      so_en_q <= 1'h1;
      if (tx_cnt_q == 3'h0) begin
        so_q     <= rd_byte[7];
        tx_q     <= rd_byte[6:0];
        tx_cnt_q <= 3'h7;
      end else begin
        so_q     <= tx_q[6];
        tx_q     <= {tx_q[5:0], 1'h0};
        tx_cnt_q <= tx_cnt_q - 3'h1;
      end
    end
  end

  // ************************************************************
  // Lock boundary decode
  // ************************************************************
  reg [11:0] lock_first_d;
  // first locked block per range code
  always @* begin
    case (lock_range_q)
      3'h0:    lock_first_d = `SNFR_BLOCK_COUNT;
      3'h7:    lock_first_d = 12'h000;
      default: lock_first_d = `SNFR_BLOCK_COUNT - (`SNFR_BLOCK_COUNT >> (3'h7 - lock_range_q));
    endcase
  end
  // ************************************************************
  // Outputs
  // ************************************************************
  assign spi_so             = so_q;
  assign spi_so_oe_n        = ~so_en_q;
  assign cmd_opcode         = cmd_opc_q;
  assign cmd_valid          = cmd_valid_q;
  assign protect_exec_ok    = prot_ok_q;
  assign param_page_mode    = ppage_q;
  assign ecc_enable         = ecc_en_q;
  assign fast_read_mode     = fast_q;
  assign hold_disable       = hold_dis_q;
  assign write_permit_latch = wpl_q;
  assign lock_first_block   = lock_first_d;
endmodule // snfr_feature_regs

// file: snfr_chk_sva.sv
// Port checker for the feature register bank, bound to its top module
`timescale 1ns/1ps
module snfr_chk (
  input wire        clock,
  input wire        reset,
  input wire        spi_cs_n,
  input wire        spi_so,
  input wire        spi_so_oe_n,
  input wire [7:0]  cmd_opcode,
  input wire        cmd_valid,
  input wire        protect_exec_ok,
  input wire        param_page_mode,
  input wire        ecc_enable,
  input wire        fast_read_mode,
  input wire        hold_disable,
  input wire        write_permit_latch,
  input wire [11:0] lock_first_block
);
  // ****************************************
  // Assertions and covers
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  pexec_opcode_a: assert property (protect_exec_ok |-> cmd_valid && cmd_opcode == 8'h2A)
    else $error("protect grant without its opcode");
  wel_set_a: assert property (cmd_valid && cmd_opcode == 8'h06 |-> ##[0:2] write_permit_latch)
    else $error("write latch not set");
  wel_clr_a: assert property (cmd_valid && cmd_opcode == 8'h04 |-> ##[0:2] !write_permit_latch)
    else $error("write latch not cleared");
  wel_rise_a: assert property ($rose(write_permit_latch) |-> cmd_opcode == 8'h06 &&
    (cmd_valid || $past(cmd_valid) || $past(cmd_valid, 2)))
    else $error("write latch set without its command");
  wel_fall_a: assert property ($fell(write_permit_latch) |-> cmd_opcode == 8'h04 &&
    (cmd_valid || $past(cmd_valid) || $past(cmd_valid, 2)))
    else $error("write latch cleared without its command");
  so_quiet_a: assert property (spi_cs_n [*8] |-> spi_so_oe_n && !spi_so)
    else $error("serial output driven outside a frame");
  lock_code_a: assert property (lock_first_block inside
    {12'h000, 12'h400, 12'h600, 12'h700, 12'h780, 12'h7C0, 12'h7E0, 12'h800})
    else $error("lock boundary not a legal range");
  cfg_frame_a: assert property ($changed({param_page_mode, ecc_enable, fast_read_mode,
    hold_disable, lock_first_block}) |-> !$past(spi_cs_n, 3))
    else $error("settings changed outside a frame");
  cover property (protect_exec_ok);
  cover property ($rose(write_permit_latch));
  cover property (lock_first_block == 12'h800 && hold_disable);
endmodule // snfr_chk
bind snfr_feature_regs snfr_chk u_chk (
  .clock(clock), .reset(reset), .spi_cs_n(spi_cs_n), .spi_so(spi_so),
  .spi_so_oe_n(spi_so_oe_n), .cmd_opcode(cmd_opcode), .cmd_valid(cmd_valid),
  .protect_exec_ok(protect_exec_ok), .param_page_mode(param_page_mode),
  .ecc_enable(ecc_enable), .fast_read_mode(fast_read_mode), .hold_disable(hold_disable),
  .write_permit_latch(write_permit_latch), .lock_first_block(lock_first_block)
);

// file: snfr_host.sv
// Serial host model issuing feature set and get frames
`timescale 1ns/1ps
`include "snfr_defines.vh"
module snfr_host (
  input  wire clock,
  input  wire spi_so,
  output reg  spi_cs_n,
  output reg  spi_sck,
  output reg  spi_si
);
  reg [7:0] cfg_shadow;
  // ****************************************
  // Frame tasks
  // ****************************************
  initial begin
    spi_cs_n   = 1'b1;
    spi_sck    = 1'b0;
    spi_si     = 1'b0;
    cfg_shadow = 8'h12;
  end
  // Whole clocks, then step off the edge
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  // byte MSB first, data sampled on rise
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        spi_si = tx[i];
        tick(8);
        spi_sck = 1'b1;
        rx[i] = spi_so;
        tick(8);
        spi_sck = 1'b0;
      end
    end
  endtask
  task frame_open;
    begin
      spi_cs_n = 1'b0;
      tick(8);
    end
  endtask
  // Released data line shows the inverse level
  task frame_close;
    begin
      tick(8);
      spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      tick(16);
    end
  endtask
  task set_feat(input [7:0] addr, input [7:0] data);
    reg [7:0] d;
    begin
      if (addr == `SNFR_ADDR_CFG)
        cfg_shadow = data & 8'h57;
      frame_open;
      xfer(`SNFR_OP_SET_FEATURE, d);
      xfer(addr, d);
      xfer(data, d);
      frame_close;
    end
  endtask
  // hold turned off before four-line loads
  task cmd(input [7:0] op);
    reg [7:0] d;
    begin
      if ((op == 8'h32 || op == 8'h34 || op == 8'hC4) && !cfg_shadow[0])
        set_feat(`SNFR_ADDR_CFG, cfg_shadow | 8'h01);
      frame_open;
      xfer(op, d);
      frame_close;
    end
  endtask
  // get: opcode, address, two repeated bytes
  task get_feat(input [7:0] addr, output [7:0] b0, output [7:0] b1);
    reg [7:0] d;
    begin
      frame_open;
      xfer(`SNFR_OP_GET_FEATURE, d);
      xfer(addr, d);
      xfer(8'hA5, b0);
      xfer(8'h5A, b1);
      frame_close;
    end
  endtask
  task poll_ready(output ok);
    reg [7:0] s0;
    reg [7:0] s1;
    integer n;
    begin
      ok = 1'b0;
      for (n = 0; n < 8 && !ok; n = n + 1) begin
        get_feat(`SNFR_ADDR_STATUS, s0, s1);
        ok = (s1[0] === 1'b0);
      end
    end
  endtask
endmodule // snfr_host

// file: snfr_tb.sv
// Self-checking bench for the feature register bank
`timescale 1ns/1ps
`include "snfr_defines.vh"
module tb;
  reg         clock, reset, wp_n, op_busy, prog_done, prog_fail, erase_done, erase_fail;
  reg         cmd_accepted, ecc_done, ecc_uncorrectable, ok;
  reg  [3:0]  ecc_flip_count, ecc_threshold;
  reg  [7:0]  b0, b1;
  reg  [11:0] lock_tab [0:7];
  wire        spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe_n, cmd_valid, protect_exec_ok;
  wire        param_page_mode, ecc_enable, fast_read_mode, hold_disable, write_permit_latch;
  wire [7:0]  cmd_opcode;
  wire [11:0] lock_first_block;
  integer     error_cnt, n_checks, pexec_cnt, i;
  snfr_feature_regs u_dut (
    .clock(clock), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .wp_n(wp_n),
    .op_busy(op_busy), .prog_done(prog_done), .prog_fail(prog_fail),
    .erase_done(erase_done), .erase_fail(erase_fail), .cmd_accepted(cmd_accepted),
    .ecc_done(ecc_done), .ecc_uncorrectable(ecc_uncorrectable),
    .ecc_flip_count(ecc_flip_count), .ecc_threshold(ecc_threshold),
    .cmd_opcode(cmd_opcode), .cmd_valid(cmd_valid), .protect_exec_ok(protect_exec_ok),
    .param_page_mode(param_page_mode), .ecc_enable(ecc_enable),
    .fast_read_mode(fast_read_mode), .hold_disable(hold_disable),
    .write_permit_latch(write_permit_latch), .lock_first_block(lock_first_block)
  );
  snfr_host u_host (
    .clock(clock), .spi_so(spi_so), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si)
  );
  // ****************************************
  // Clock, counters and tasks
  // ****************************************
  always #4 clock = ~clock;
  always @(posedge clock) begin
    if (protect_exec_ok === 1'b1)
      pexec_cnt = pexec_cnt + 1;
  end
  task check(input [63:0] got, input [63:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
    end
  endtask
  // Read a feature byte twice within one frame
  task rd(input [7:0] a, input [7:0] exp);
    begin
      u_host.get_feat(a, b0, b1);
      check(b0, exp);
      check(b1, exp);
    end
  endtask
  // One-cycle strobes: program, erase, correction, accepted
  task pulse(input [3:0] sel);
    begin
      {prog_done, erase_done, ecc_done, cmd_accepted} = sel;
      @(posedge clock);
      #1;
      {prog_done, erase_done, ecc_done, cmd_accepted} = 4'h0;
      repeat (2) @(posedge clock);
      #1;
    end
  endtask
  task conclude;
    begin
      if (error_cnt == 0 && n_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt = error_cnt + 1;
    conclude;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {clock, wp_n, op_busy, prog_done, prog_fail, erase_done, erase_fail} = 7'h20;
    {cmd_accepted, ecc_done, ecc_uncorrectable, ecc_flip_count, ecc_threshold} = 11'h0;
    reset = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    pexec_cnt = 0;
    lock_tab[0] = 12'h800; lock_tab[1] = 12'h7E0; lock_tab[2] = 12'h7C0; lock_tab[3] = 12'h780;
    lock_tab[4] = 12'h700; lock_tab[5] = 12'h600; lock_tab[6] = 12'h400; lock_tab[7] = 12'h000;
    repeat (10) @(posedge clock);
    #1;
    reset = 1'b0;
    rd(`SNFR_ADDR_LOCK, 8'h38);
    check(spi_so_oe_n, 1'b1);
    check(lock_first_block, 12'h000);
    rd(`SNFR_ADDR_CFG, 8'h12);
    check({param_page_mode, ecc_enable, fast_read_mode, hold_disable}, 4'h6);
    rd(`SNFR_ADDR_STATUS, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      u_host.set_feat(`SNFR_ADDR_LOCK, {2'h1, i[2:0], 3'h7});
      rd(`SNFR_ADDR_LOCK, {2'h0, i[2:0], 3'h0});
      check(lock_first_block, lock_tab[i]);
    end
    u_host.set_feat(`SNFR_ADDR_CFG, 8'hFF);
    rd(`SNFR_ADDR_CFG, 8'h57);
    check({param_page_mode, ecc_enable, fast_read_mode, hold_disable}, 4'hF);
    u_host.cmd(`SNFR_OP_PROTECT_EXEC);
    check({pexec_cnt[3:0], cmd_opcode}, 12'h12A);
    u_host.set_feat(`SNFR_ADDR_CFG, 8'h00);
    check({param_page_mode, ecc_enable, fast_read_mode, hold_disable}, 4'h0);
    u_host.cmd(`SNFR_OP_PROTECT_EXEC);
    check(pexec_cnt, 1);
    u_host.cmd(8'h32);
    check(hold_disable, 1'b1);
    u_host.cmd(`SNFR_OP_WRITE_ENABLE);
    u_host.set_feat(`SNFR_ADDR_STATUS, 8'h00);
    rd(`SNFR_ADDR_STATUS, 8'h02);
    u_host.cmd(8'hFF);
    u_host.cmd(8'hFE);
    rd(`SNFR_ADDR_CFG, 8'h01);
    u_host.cmd(`SNFR_OP_WRITE_DISABLE);
    u_host.set_feat(`SNFR_ADDR_STATUS, 8'hFF);
    rd(`SNFR_ADDR_STATUS, 8'h00);
    u_host.set_feat(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    u_host.set_feat(`SNFR_ADDR_LOCK, 8'h90);
    wp_n = 1'b0;
    u_host.set_feat(`SNFR_ADDR_LOCK, 8'h00);
    rd(`SNFR_ADDR_LOCK, 8'h90);
    wp_n = 1'b1;
    u_host.set_feat(`SNFR_ADDR_LOCK, 8'h00);
    rd(`SNFR_ADDR_LOCK, 8'h00);
    ecc_uncorrectable = 1'b1;
    pulse(4'h2);
    rd(`SNFR_ADDR_STATUS, 8'h00);
    u_host.set_feat(`SNFR_ADDR_CFG, 8'h11);
    for (i = 0; i < 4; i = i + 1) begin
      ecc_threshold = 4'h5;
      ecc_flip_count = (i == 1) ? 4'h4 : (i == 3) ? 4'h5 : 4'h0;
      ecc_uncorrectable = (i == 2);
      pulse(4'h2);
      rd(`SNFR_ADDR_STATUS, {2'h0, i[1:0], 4'h0});
    end
    fork
      u_host.get_feat(`SNFR_ADDR_STATUS, b0, b1);
      begin
        repeat (300) @(posedge clock);
        #1;
        op_busy = 1'b1;
        prog_fail = 1'b1;
        pulse(4'h8);
      end
    join
    check({b0, b1}, 16'h3039);
    op_busy = 1'b0;
    u_host.poll_ready(ok);
    check(ok, 1'b1);
    if (ok !== 1'b1)
      conclude;
    erase_fail = 1'b1;
    pulse(4'h4);
    rd(`SNFR_ADDR_STATUS, 8'h3C);
    pulse(4'h1);
    rd(`SNFR_ADDR_STATUS, 8'h30);
    conclude;
  end
endmodule // tb
